/* File: adcc_control.sv */
// Purpose: Control logic of a 10-bit successive approximation converter
// Assumes: Control bits arrive as same-clock ports; rc_clock is asynchronous
// Notes: Analog blocks sit outside; comp_above answers the current dac_code
//
// What this block does
// RULE_01: Select field picks divider or RC clock
// RULE_02: One conversion spans eleven bit periods
// RULE_03: Channel field drives sample and hold mux
// RULE_04: Reference bit picks supply or pin; ground
// RULE_05: Done flag set every conversion, software clears
// RULE_06: Enabled flag raises interrupt, wakes from sleep
// RULE_07: Runs only when enabled; go starts conversion
// RULE_08: Software enables first, then starts
// RULE_09: Completion clears go, flags, loads result
// RULE_10: Software abort keeps previous result untouched
// RULE_11: Abort waits two periods, then acquires again
// RULE_12: Reset turns converter off, ends conversion; code only ends it, analog_power still follows converter_enable
// RULE_13: RC clock delays start one instruction
// RULE_14: Sleep with RC completes; no irq powers off
// RULE_15: Sleep without RC aborts and powers off
// RULE_16: Special trigger sets go, clears timer
// RULE_17: Result left or right justified by bit
// RULE_18: Software waits settling after channel change
// RULE_19: Divided clocks follow system clock; RC not
// RULE_20: Software waits acquisition, polls, clears flag
// RULE_21: Left: eight high, two atop low
// RULE_22: Go while disabled starts nothing
`timescale 1ns/1ps
`default_nettype none
`include "adcc_map.svh"

module adcc_control (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic [`ADCC_SEL_W-1:0] conv_clock_select,
	input wire logic [`ADCC_CHAN_W-1:0] input_channel_select,
	input wire logic pos_reference_select,
	input wire logic result_justify_select,
	input wire logic converter_enable,
	input wire logic conversion_irq_enable,
	input wire logic go_set,
	input wire logic go_clear,
	input wire logic flag_clear,
	input wire logic sleep_mode,
	input wire logic capture_compare_trigger,
	input wire logic rc_clock,
	input wire logic comp_above,
	output logic go_busy,
	output logic conversion_done_flag,
	output logic irq_request,
	output logic wake_request,
	output logic [7:0] result_high,
	output logic [7:0] result_low,
	output logic [`ADCC_RES_W-1:0] dac_code,
	output logic [`ADCC_CHAN_W-1:0] mux_channel,
	output logic ref_pos_external,
	output logic ref_neg_ground,
	output logic analog_power,
	output logic sample_hold_connect,
	output logic timer_clear,
	output var adcc_pkg::adcc_state_type conv_state
);
	import adcc_pkg::*;

	// ==========================================
	// Helpers
	function automatic logic [`ADCC_DIV_W-1:0] div_len(input logic [`ADCC_SEL_W-1:0] sel);
		logic [2:0] e;
		e = {sel[1:0], sel[2]} + 3'h1;
		div_len = `ADCC_DIV_W'((7'h01 << e) - 7'h01);
	endfunction : div_len

	function automatic logic [15:0] justify(input logic [`ADCC_RES_W-1:0] r, input logic right);
		justify = right ? {6'h00, r} : {r, 6'h00};
	endfunction : justify

	// Everything it reads is an argument, so the trial code follows comparator and code alike
	function automatic logic [`ADCC_RES_W-1:0] sar_keep(input logic [`ADCC_RES_W-1:0] s,
		input logic [`ADCC_RES_W-1:0] b, input logic above);
		sar_keep = above ? s : (s & ~b);
	endfunction : sar_keep

	// ==========================================
	// State
	adcc_state_type state;
	adcc_state_type next_state;
	logic [`ADCC_DIV_W-1:0] div_cnt;
	logic [`ADCC_STEP_W-1:0] step;
	logic [2:0] dly_cnt;
	logic [`ADCC_RES_W-1:0] res;
	logic powered_down;
	logic rc_s1;
	logic rc_s2;
	logic rc_s3;
	logic rc_lvl;

	// ==========================================
	// Decoding
	wire rc_sel = conv_clock_select[1:0] == `ADCC_RC_CODE;
	wire [`ADCC_DIV_W-1:0] div_top = div_len(conv_clock_select);
	wire div_tick = div_cnt >= div_top;
	// Only a settled RC level counts, so a glitch cannot add a bit period
	wire rc_tick = rc_s2 & rc_s3 & ~rc_lvl;
	wire tad_tick = rc_sel ? rc_tick : div_tick; // RULE_19
	wire in_idle = state == st_idle;
	wire in_conv = state == st_conv;
	wire in_rec = state == st_recover;
	wire running = in_conv | (state == st_delay);
	wire sw_start = go_set & converter_enable & ~powered_down; // RULE_22
	wire trig_start = capture_compare_trigger & converter_enable & ~powered_down; // RULE_16
	wire start_req = in_idle & (sw_start | trig_start); // RULE_07
	wire sleep_abort = sleep_mode & ~rc_sel & running; // RULE_15
	wire off_abort = ~converter_enable & ~in_idle;
	wire kill = off_abort | sleep_abort;
	wire sw_abort = running & go_clear & ~kill; // RULE_10
	wire last_step = step == `ADCC_CONV_TAD - 4'h1;
	wire conv_done = in_conv & tad_tick & last_step & ~go_clear & ~kill; // RULE_02
	wire rec_done = in_rec & tad_tick & (step == `ADCC_RECOVER_TAD - 4'h1); // RULE_11
	wire state_chg = next_state != state;
	wire [`ADCC_RES_W-1:0] cur_bit = `ADCC_SAR_MSB >> (step - 4'h1);
	wire [`ADCC_RES_W-1:0] trial_sar = sar_keep(dac_code, cur_bit, comp_above) | (cur_bit >> 1);
	wire [15:0] formatted = justify(res, result_justify_select); // RULE_17 RULE_21
	wire rc_sleep_off = conv_done & sleep_mode & rc_sel & ~conversion_irq_enable; // RULE_14

	// ==========================================
	// Pass-through selections, fixed ground and simple gated outputs
	assign mux_channel = input_channel_select; // RULE_03
	assign ref_pos_external = pos_reference_select; // RULE_04
	assign ref_neg_ground = 1'b1; // RULE_04
	assign analog_power = converter_enable & ~powered_down; // RULE_07
	// Acquisition restarts by itself once idle, including after a recovery
	assign sample_hold_connect = analog_power & in_idle; // RULE_11
	assign irq_request = conversion_done_flag & conversion_irq_enable; // RULE_06
	assign wake_request = irq_request & sleep_mode; // RULE_06
	assign conv_state = state;

	// ==========================================
	// Sequencer
	always_comb begin
		next_state = state;
		unique case (state)
			st_idle: begin
				if (start_req) next_state = rc_sel ? st_delay : st_conv; // RULE_13
			end
			st_delay: begin
				if (kill) next_state = st_idle;
				else if (sw_abort) next_state = st_recover;
				else if (dly_cnt == `ADCC_INSTR_CLKS - 3'h1) next_state = st_conv; // RULE_13
			end
			st_conv: begin
				if (kill) next_state = st_idle;
				else if (sw_abort) next_state = st_recover; // RULE_11
				else if (conv_done) next_state = st_idle; // RULE_09
			end
			st_recover: begin
				if (off_abort) next_state = st_idle;
				else if (rec_done) next_state = st_idle; // RULE_11
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) state <= st_idle; // RULE_12
		else state <= next_state;
	end

	// ==========================================
	// Bit clock
	// Divider restarts on each state change so every phase gets whole periods
	always_ff @(posedge ref_clk) begin
		if (sys_rst || state_chg || div_tick) div_cnt <= '0; // RULE_01
		else div_cnt <= div_cnt + `ADCC_DIV_W'(1);
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rc_s1 <= 1'b0;
			rc_s2 <= 1'b0;
			rc_s3 <= 1'b0;
		end else begin
			rc_s1 <= rc_clock;
			rc_s2 <= rc_s1;
			rc_s3 <= rc_s2;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) rc_lvl <= 1'b0;
		else if (rc_s2 == rc_s3) rc_lvl <= rc_s3;
	end

	// ==========================================
	// Counters
	always_ff @(posedge ref_clk) begin
		if (sys_rst || state_chg) step <= '0;
		else if (tad_tick && (in_conv || in_rec)) step <= step + `ADCC_STEP_W'(1); // RULE_02
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst || state_chg) dly_cnt <= '0;
		else if (state == st_delay) dly_cnt <= dly_cnt + 3'h1;
	end

	// ==========================================
	// Approximation register
	// First period only holds the sample; ten periods then resolve one bit each
	always_ff @(posedge ref_clk) begin
		if (sys_rst) dac_code <= '0;
		else if (state_chg && next_state == st_conv) dac_code <= `ADCC_SAR_MSB;
		else if (in_conv && tad_tick && step != '0) dac_code <= trial_sar;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) res <= '0;
		else if (conv_done) res <= trial_sar; // RULE_09 RULE_10
	end

	// Result pair trails the stored value by one clock
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			result_high <= 8'h00;
			result_low <= 8'h00;
		end else begin
			result_high <= formatted[15:8]; // RULE_21
			result_low <= formatted[7:0]; // RULE_21
		end
	end

	// ==========================================
	// Status bits
	always_ff @(posedge ref_clk) begin
		if (sys_rst) go_busy <= 1'b0; // RULE_12
		else if (start_req) go_busy <= 1'b1; // RULE_07 RULE_16
		else if (conv_done || kill || go_clear) go_busy <= 1'b0; // RULE_09
	end

	// A completion in the clearing cycle still sets the flag
	always_ff @(posedge ref_clk) begin
		if (sys_rst) conversion_done_flag <= 1'b0;
		else if (conv_done) conversion_done_flag <= 1'b1; // RULE_05
		else if (flag_clear) conversion_done_flag <= 1'b0; // RULE_05
	end

	// Enable bit stays set while powered down; leaving sleep powers back up
	always_ff @(posedge ref_clk) begin
		if (sys_rst) powered_down <= 1'b0;
		else if (sleep_abort || rc_sleep_off) powered_down <= 1'b1; // RULE_14 RULE_15
		else if (!sleep_mode) powered_down <= 1'b0;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) timer_clear <= 1'b0;
		else timer_clear <= capture_compare_trigger; // RULE_16
	end

	// ==========================================
	// Checks
	logic [`ADCC_STEP_W-1:0] tad_seen;
	always_ff @(posedge ref_clk) begin
		if (sys_rst || state_chg || in_idle) tad_seen <= '0;
		else if (tad_tick) tad_seen <= tad_seen + `ADCC_STEP_W'(1);
	end

	wire calm = !go_clear && converter_enable && !sleep_mode;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);

	div_two_rate_a: assert property ( // RULE_01
		(in_conv && conv_clock_select == 3'h0 && div_tick ##1 in_conv && conv_clock_select == 3'h0 && !state_chg)
		|-> ##1 div_tick)
		else $error("divide-by-two bit clock lost its rate");
	conv_eleven_a: assert property (conv_done |-> tad_seen == 4'ha) // RULE_02
		else $error("conversion did not take eleven bit periods");
	flag_set_a: assert property (conv_done |=> conversion_done_flag) // RULE_05
		else $error("done flag not set on completion");
	flag_hold_a: assert property (conversion_done_flag && !flag_clear |=> conversion_done_flag) // RULE_05
		else $error("done flag dropped without software clear");
	wake_out_a: assert property ( // RULE_06
		conv_done && conversion_irq_enable && sleep_mode ##1 conversion_irq_enable && sleep_mode
		|-> irq_request && wake_request)
		else $error("enabled completion did not wake");
	done_seq_a: assert property (conv_done |=> !go_busy && in_idle ##1 {result_high, result_low} == $past(formatted)) // RULE_09
		else $error("completion did not clear go and load result");
	abort_keep_a: assert property (sw_abort |=> $stable(res) && in_rec && !go_busy) // RULE_10
		else $error("abort changed result or skipped recovery");
	recover_two_a: assert property ( // RULE_11
		in_rec && next_state == st_idle && !off_abort |-> tad_tick && tad_seen == 4'h1)
		else $error("recovery did not last two bit periods");
	rc_delay_a: assert property ((start_req && rc_sel ##1 calm [*4]) |=> in_conv) // RULE_13
		else $error("RC start not delayed by one instruction");
	sleep_kill_a: assert property ( // RULE_15
		sleep_mode && !rc_sel && in_conv |=> in_idle && !analog_power && !go_busy)
		else $error("sleep did not abort a divided-clock conversion");
	rc_sleep_off_a: assert property (rc_sleep_off |=> !analog_power && converter_enable) // RULE_14
		else $error("RC sleep completion did not power off");
	no_start_off_a: assert property ( // RULE_22
		in_idle && !go_busy && !converter_enable |=> !go_busy && in_idle)
		else $error("disabled converter started");
	trig_timer_a: assert property (capture_compare_trigger |=> timer_clear) // RULE_16
		else $error("trigger did not clear timer");
	reset_off_a: assert property ( // RULE_12
		@(posedge ref_clk) disable iff (1'b0) sys_rst |=> !go_busy && in_idle && !conversion_done_flag)
		else $error("reset left conversion running");

	// Start, stop and power paths
	start_busy_a: assert property (start_req |=> go_busy && !in_idle) // RULE_07
		else $error("accepted start did not raise busy");
	busy_running_a: assert property (running |-> go_busy) // RULE_07
		else $error("conversion running without busy");
	off_abort_a: assert property (off_abort |=> in_idle && !go_busy) // RULE_07
		else $error("disable did not stop the converter");
	trig_go_a: assert property (trig_start && in_idle |=> go_busy) // RULE_16
		else $error("trigger did not set busy");
	timer_once_a: assert property (!capture_compare_trigger |=> !timer_clear) // RULE_16
		else $error("timer clear without trigger");
	powered_wake_a: assert property (powered_down && !sleep_mode |=> !powered_down) // RULE_15
		else $error("converter stayed off after sleep");

	// Sequencing and abort detail
	dac_start_a: assert property (state_chg && next_state == st_conv |=> dac_code == `ADCC_SAR_MSB) // RULE_02
		else $error("conversion did not start from mid code");
	delay_hold_a: assert property ( // RULE_13
		state == st_delay && dly_cnt != `ADCC_INSTR_CLKS - 3'h1 && !kill && !sw_abort |=> state == st_delay)
		else $error("RC start delay cut short");
	abort_noflag_a: assert property (sw_abort && !conversion_done_flag |=> !conversion_done_flag) // RULE_10
		else $error("aborted conversion set the done flag");
	reacquire_a: assert property ( // RULE_11
		rec_done && !off_abort ##1 converter_enable |-> sample_hold_connect)
		else $error("acquisition did not restart after recovery");
	rc_single_a: assert property (rc_tick |=> !rc_tick) // RULE_19
		else $error("one RC edge gave two bit periods");
	div_only_a: assert property ( // RULE_19
		!rc_sel && in_conv && !div_tick && !state_chg |=> $stable(step))
		else $error("divided clock stepped without a divider tick");

	// ==========================================
	// Cover points
	full_conv_c: cover property (conv_done && conversion_irq_enable);
	sleep_abort_c: cover property (sleep_abort);
	sw_abort_c: cover property (sw_abort ##[1:200] rec_done);
	rc_sleep_c: cover property (rc_sleep_off);
	trig_start_c: cover property (trig_start && in_idle);
endmodule : adcc_control
`default_nettype wire

/* File: adcc_map.svh */
// Purpose: Field widths, field codes and timing counts of the converter control
// Assumes: System clock is also the instruction clock source, 4 per cycle
// Notes: Definitions only
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH

// ==========================================
// Field widths
`define ADCC_SEL_W 3
`define ADCC_CHAN_W 4
`define ADCC_RES_W 10
`define ADCC_DIV_W 6
`define ADCC_STEP_W 4

// ==========================================
// Field codes
`define ADCC_RC_CODE 2'h3
`define ADCC_JUSTIFY_RIGHT 1'b1
`define ADCC_SAR_MSB 10'h200

// ==========================================
// Timing counts
`define ADCC_CLK_PERIOD_NS 5
`define ADCC_CONV_TAD 4'hb
`define ADCC_RECOVER_TAD 4'h2
`define ADCC_INSTR_CLKS 3'h4

`endif

/* File: adcc_pkg.sv */
// Purpose: Types shared by the converter control
// Assumes: Nothing beyond the map header
// Notes: Constants live in adcc_map.svh
`default_nettype none
package adcc_pkg;
	// ==========================================
	// Sequencer states
	typedef enum logic [1:0] {
		st_idle,
		st_delay,
		st_conv,
		st_recover
	} adcc_state_type;
endpackage : adcc_pkg
`default_nettype wire

/* File: tb.sv */
// Purpose: Self-checking bench for the converter control block
// Assumes: Inputs change at the falling edge of ref_clk
// Notes: Comparator answers from a target code, so each result is known
`timescale 1ns/1ps
`default_nettype none
module tb;
	import adcc_pkg::*;
	// ==========================================
	// Signals
	typedef struct {logic [2:0] sel; logic [9:0] val; logic just; int div;} adcc_row_type;
	logic ref_clk = 1'b0, sys_rst = 1'b1, pos_ref = 1'b0, just = 1'b0, cen = 1'b0, irq_en = 1'b0;
	logic go_set = 1'b0, go_clear = 1'b0, flag_clear = 1'b0, sleep_mode = 1'b0, trig = 1'b0;
	logic rc_clock = 1'b0, comp_above = 1'b0;
	logic [2:0] sel = 3'h0;
	logic [3:0] chan = 4'h0;
	logic [9:0] target = 10'h0;
	logic go_busy, flag, irq, wake, ref_ext, ref_gnd, apower, sh_conn, tclr;
	logic [7:0] res_h, res_l;
	logic [9:0] dac;
	logic [3:0] mux;
	adcc_state_type st;
	int error_cnt = 0, n_checks = 0, cycle_cnt = 0, rc_cnt = 0, cnt;
	logic [15:0] exp_res;
	adcc_row_type rows [6] = '{'{3'h0, 10'h2a5, 1'b1, 2}, '{3'h4, 10'h3ff, 1'b0, 4},
		'{3'h1, 10'h000, 1'b1, 8}, '{3'h5, 10'h155, 1'b0, 16}, '{3'h2, 10'h1c3, 1'b1, 32},
		'{3'h6, 10'h301, 1'b0, 64}};
	adcc_control dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .conv_clock_select(sel),
		.input_channel_select(chan), .pos_reference_select(pos_ref), .result_justify_select(just),
		.converter_enable(cen), .conversion_irq_enable(irq_en), .go_set(go_set), .go_clear(go_clear),
		.flag_clear(flag_clear), .sleep_mode(sleep_mode), .capture_compare_trigger(trig),
		.rc_clock(rc_clock), .comp_above(comp_above), .go_busy(go_busy), .conversion_done_flag(flag),
		.irq_request(irq), .wake_request(wake), .result_high(res_h), .result_low(res_l), .dac_code(dac),
		.mux_channel(mux), .ref_pos_external(ref_ext), .ref_neg_ground(ref_gnd), .analog_power(apower),
		.sample_hold_connect(sh_conn), .timer_clear(tclr), .conv_state(st));
	// ==========================================
	// Clock, comparator, RC oscillator, timeout
	always #2.5 ref_clk = ~ref_clk;
	// Slow RC edges keep the three-flop synchroniser well clear of metastable timing
	always @(negedge ref_clk) begin
		comp_above <= (target >= dac);
		rc_cnt <= (rc_cnt == 2) ? 0 : rc_cnt + 1;
		if (rc_cnt == 2) rc_clock <= ~rc_clock;
	end
	always @(posedge ref_clk) begin
		cycle_cnt <= cycle_cnt + 1;
		if (cycle_cnt == 20000) begin
			error_cnt = error_cnt + 1;
			give_verdict();
		end
	end
	// ==========================================
	// Helpers
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_checks = n_checks + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask : cyc
	task automatic pulse_go();
		go_set = 1'b1;
		cyc(1);
		go_set = 1'b0;
	endtask : pulse_go
	// Bounded wait so a stuck busy bit cannot hang the run
	task automatic wait_idle(output int n);
		n = 0;
		while (go_busy === 1'b1 && n < 3000) begin
			cyc(1);
			n = n + 1;
		end
	endtask : wait_idle
	task automatic give_verdict();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : give_verdict
	// ==========================================
	// Main sequence
	initial begin
		cyc(6);
		sys_rst = 1'b0;
		cyc(1);
		chk("rst ctl", {12'h0, go_busy, flag, 2'(st)}, 16'h0);
		chk("rst res", {res_h, res_l}, 16'h0);
		pulse_go();
		cyc(2);
		chk("go disabled", {15'h0, go_busy}, 16'h0);
		cen = 1'b1;
		cyc(4);
		foreach (rows[i]) begin
			sel = rows[i].sel;
			just = rows[i].just;
			target = rows[i].val;
			chan = 4'(i);
			pos_ref = i[0];
			irq_en = i[0];
			cyc(2);
			chk("mux", {12'h0, mux}, 16'(i));
			chk("refs", {14'h0, ref_ext, ref_gnd}, {14'h0, pos_ref, 1'b1});
			pulse_go();
			wait_idle(cnt);
			chk("busy len", 16'(cnt), 16'(11 * rows[i].div));
			cyc(2);
			exp_res = just ? {6'h0, target} : {target, 6'h0};
			chk("result", {res_h, res_l}, exp_res);
			chk("flag irq", {14'h0, flag, irq}, {14'h0, 1'b1, irq_en});
			flag_clear = 1'b1;
			cyc(1);
			flag_clear = 1'b0;
			cyc(1);
			chk("flag clr", {15'h0, flag}, 16'h0);
		end
		sel = 3'h4;
		target = 10'h0aa;
		pulse_go();
		cyc(10);
		go_clear = 1'b1;
		cyc(1);
		go_clear = 1'b0;
		chk("abort", {14'h0, go_busy, flag}, 16'h0);
		chk("recover", {14'h0, 2'(st)}, {14'h0, 2'(st_recover)});
		cnt = 0;
		while (st !== st_idle && cnt < 50) begin
			cyc(1);
			cnt = cnt + 1;
		end
		chk("rec len", 16'(cnt), 16'(2 * 4));
		chk("reacquire", {15'h0, sh_conn}, 16'h1);
		chk("kept", {res_h, res_l}, exp_res);
		sel = 3'h6;
		pulse_go();
		cyc(20);
		sleep_mode = 1'b1;
		cyc(2);
		chk("sleep abort", {14'h0, go_busy, apower}, 16'h0);
		sleep_mode = 1'b0;
		cyc(2);
		chk("power back", {15'h0, apower}, 16'h1);
		sel = 3'h3;
		just = 1'b1;
		irq_en = 1'b1;
		target = 10'h1f0;
		pulse_go();
		chk("rc delay", {14'h0, 2'(st)}, {14'h0, 2'(st_delay)});
		cyc(4);
		chk("rc conv", {14'h0, 2'(st)}, {14'h0, 2'(st_conv)});
		sleep_mode = 1'b1;
		wait_idle(cnt);
		cyc(2);
		chk("rc sleep", {res_h, res_l}, {6'h0, target});
		chk("wake", {14'h0, flag, wake}, 16'h3);
		flag_clear = 1'b1;
		irq_en = 1'b0;
		cyc(1);
		flag_clear = 1'b0;
		sleep_mode = 1'b0;
		sel = 3'h7;
		cyc(2);
		pulse_go();
		cyc(4);
		sleep_mode = 1'b1;
		wait_idle(cnt);
		cyc(2);
		chk("rc off", {14'h0, flag, apower}, 16'h2);
		sleep_mode = 1'b0;
		sel = 3'h0;
		cyc(2);
		trig = 1'b1;
		cyc(1);
		trig = 1'b0;
		chk("trigger", {14'h0, go_busy, tclr}, 16'h3);
		cyc(5);
		cen = 1'b0;
		cyc(1);
		chk("off abort", {12'h0, go_busy, apower, 2'(st)}, {12'h0, 1'b0, 1'b0, 2'(st_idle)});
		cen = 1'b1;
		cyc(2);
		pulse_go();
		cyc(5);
		chk("restart", {15'h0, go_busy}, 16'h1);
		sys_rst = 1'b1;
		cyc(1);
		sys_rst = 1'b0;
		chk("mid ctl", {12'h0, go_busy, flag, 2'(st)}, 16'h0);
		chk("mid res", {res_h, res_l}, 16'h0);
		give_verdict();
	end
endmodule : tb
`default_nettype wire
